// ==== core/link_stream_pkg.sv ====
// Shared constants for the user stream port of a 64b/66b serial link.
// Assumes one user clock shared by the core end and the user end.
package link_stream_pkg;
  localparam int          WORD_BYTES     = 8;
  localparam int          DATA_W         = 64;
  localparam int          KEEP_W         = 4;
  localparam int          BLOCK_W        = 66;
  localparam logic [1:0]  HDR_DATA       = 2'h1;
  localparam logic [1:0]  HDR_CTRL       = 2'h2;
  localparam logic [7:0]  TYPE_IDLE      = 8'h78;
  localparam logic [7:0]  TYPE_SEP       = 8'h1E;
  localparam logic [7:0]  TYPE_CC        = 8'h55;
  localparam int          SEP_CNT_LSB    = 8;
  localparam int          CRC_KEEP_LSB   = 32;
  localparam logic [3:0]  KEEP_FULL      = 4'h8;
  localparam logic [3:0]  CRC_BLOCK_CNT  = 4'h5;
  localparam logic [31:0] CRC_POLY       = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT       = 32'hFFFFFFFF;
  localparam int          GEARBOX_PERIOD = 32;
  localparam int          CC_LEN         = 3;
  localparam int          CC_PERIOD      = 10000;
  localparam int          USER_DEPTH     = 16;
endpackage

// ==== core/stream_port_if.sv ====
// Carrier between the core end and the user end of the stream port.
// Assumes both ends run on the same user clock.
`timescale 1ns/100ps
interface stream_port_if;
  logic [link_stream_pkg::DATA_W-1:0] tx_data;
  logic                               tx_valid;
  logic                               tx_last;
  logic [link_stream_pkg::KEEP_W-1:0] tx_keep;
  logic                               tx_ready;
  logic [link_stream_pkg::DATA_W-1:0] rx_data;
  logic                               rx_valid;
  logic                               rx_last;
  logic [link_stream_pkg::KEEP_W-1:0] rx_keep;

  modport device (
    input  tx_data, tx_valid, tx_last, tx_keep,
    output tx_ready, rx_data, rx_valid, rx_last, rx_keep
  );
  modport user (
    output tx_data, tx_valid, tx_last, tx_keep,
    input  tx_ready, rx_data, rx_valid, rx_last, rx_keep
  );
endinterface // stream_port_if

// ==== core/stream_port_device.sv ====
// Core end of the user stream port: tx framing onto one lane, rx deframing.
// Assumes a single lane, one 66-bit block slot per user clock.
`timescale 1ns/100ps
module stream_port_device #(
  parameter bit FRAMING    = 1'b1,
  parameter bit GEARBOX_EN = 1'b1,
  parameter bit CRC_EN     = 1'b0,
  parameter int CC_PERIOD  = link_stream_pkg::CC_PERIOD
) (
  input  wire logic                                 ref_clk_i,
  input  wire logic                                 rst_n_i,
  stream_port_if.device                             port,
  input  wire logic                                 channel_up_i,
  output logic [link_stream_pkg::BLOCK_W-1:0]       lane_tx_block_o,
  output logic                                      lane_tx_slot_o,
  output logic                                      clock_comp_request_o,
  input  wire logic [link_stream_pkg::BLOCK_W-1:0]  lane_rx_block_i,
  input  wire logic                                 lane_rx_valid_i,
  output logic                                      crc_error_o
);
  localparam int         GBW     = $clog2(link_stream_pkg::GEARBOX_PERIOD);
  localparam int         CCW     = $clog2(CC_PERIOD);
  localparam int         DW      = link_stream_pkg::DATA_W;
  localparam logic [GBW-1:0] GB_LAST = GBW'(link_stream_pkg::GEARBOX_PERIOD - 1);
  localparam logic [CCW-1:0] CC_LAST = CCW'(CC_PERIOD - 1);
  localparam logic [CCW-1:0] CC_END  = CCW'(link_stream_pkg::CC_LEN);

  typedef enum logic [2:0] {
    TX_BODY = 3'b001,
    TX_CRC  = 3'b010,
    TX_SEP  = 3'b100
  } tx_state_t;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [DW-1:0] d);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < DW; i++) begin
      fb = r[31] ^ d[i];
      r  = {r[30:0], 1'b0} ^ (fb ? link_stream_pkg::CRC_POLY : 32'h0);
    end
    return r;
  endfunction

  // Zero every byte at or above the count
  function automatic logic [DW-1:0] keep_mask(input logic [DW-1:0] d, input logic [3:0] k);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < link_stream_pkg::WORD_BYTES; i++) begin
      if (i < int'(k)) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic [GBW-1:0]  gb_cnt_r;
  logic [GBW-1:0]  gb_cnt_nxt;
  logic [CCW-1:0]  cc_cnt_r;
  logic [CCW-1:0]  cc_cnt_nxt;
  tx_state_t       tx_st_r;
  tx_state_t       tx_st_nxt;
  logic            pause_now;
  logic            pause_nxt;
  logic            cc_now;
  logic            cc_nxt;
  logic            slot_free;
  logic            accept;
  logic [DW-1:0]   tx_word;
  logic [3:0]      last_keep_r;
  logic [31:0]     tx_crc_r;

  // Slot timing: gearbox pause and compensation windows
  assign gb_cnt_nxt = (gb_cnt_r == GB_LAST) ? '0 : gb_cnt_r + GBW'(1);
  assign cc_cnt_nxt = (cc_cnt_r == CC_LAST) ? '0 : cc_cnt_r + CCW'(1);
  assign pause_now  = GEARBOX_EN && (gb_cnt_r == GB_LAST);
  assign pause_nxt  = GEARBOX_EN && (gb_cnt_nxt == GB_LAST);
  assign cc_now     = cc_cnt_r < CC_END;
  assign cc_nxt     = cc_cnt_nxt < CC_END;
  assign slot_free  = !pause_now && !cc_now;
  assign accept     = port.tx_valid && port.tx_ready;
  assign tx_word    = (FRAMING && port.tx_last) ?
                      keep_mask(port.tx_data, port.tx_keep) : port.tx_data;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      gb_cnt_r <= '0;
      cc_cnt_r <= '0;
    end else begin
      gb_cnt_r <= gb_cnt_nxt;
      cc_cnt_r <= cc_cnt_nxt;
    end
  end

  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      TX_BODY: begin
        if (FRAMING && accept && port.tx_last) begin
          tx_st_nxt = CRC_EN ? TX_CRC : TX_SEP;
        end
      end
      TX_CRC: begin
        if (slot_free) begin
          tx_st_nxt = TX_SEP;
        end
      end
      TX_SEP: begin
        if (slot_free) begin
          tx_st_nxt = TX_BODY;
        end
      end
      default: tx_st_nxt = TX_BODY;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !channel_up_i) begin
      tx_st_r <= TX_BODY;
    end else begin
      tx_st_r <= tx_st_nxt;
    end
  end

  // Ready for the coming cycle, low in pause, compensation and frame tail
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      port.tx_ready        <= 1'b0;
      clock_comp_request_o <= 1'b0;
    end else begin
      port.tx_ready        <= channel_up_i && !pause_nxt && !cc_nxt &&
                              (tx_st_nxt == TX_BODY);
      clock_comp_request_o <= cc_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      last_keep_r <= link_stream_pkg::KEEP_FULL;
      tx_crc_r    <= link_stream_pkg::CRC_INIT;
    end else begin
      if (accept) begin
        tx_crc_r <= crc_step(tx_crc_r, tx_word);
        if (port.tx_last) begin
          last_keep_r <= port.tx_keep;
        end
      end else if (tx_st_r == TX_SEP && slot_free) begin
        tx_crc_r <= link_stream_pkg::CRC_INIT;
      end
    end
  end

  // One block per slot; data only when a word is taken or the CRC block is sent, so a slot
  // never carries data behind an idle or a separator
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      lane_tx_slot_o  <= 1'b0;
      lane_tx_block_o <= {link_stream_pkg::HDR_CTRL, 56'h0, link_stream_pkg::TYPE_IDLE};
    end else if (pause_now) begin
      lane_tx_slot_o <= 1'b0;
    end else begin
      lane_tx_slot_o <= 1'b1;
      if (cc_now) begin
        lane_tx_block_o <= {link_stream_pkg::HDR_CTRL, 56'h0, link_stream_pkg::TYPE_CC};
      end else if (tx_st_r == TX_CRC) begin
        lane_tx_block_o <= {link_stream_pkg::HDR_DATA, 28'h0, last_keep_r, tx_crc_r};
      end else if (tx_st_r == TX_SEP) begin
        lane_tx_block_o <= {link_stream_pkg::HDR_CTRL, 48'h0, 4'h0,
                            CRC_EN ? link_stream_pkg::CRC_BLOCK_CNT : last_keep_r,
                            link_stream_pkg::TYPE_SEP};
      end else if (accept) begin
        lane_tx_block_o <= {link_stream_pkg::HDR_DATA, tx_word};
      end else begin
        lane_tx_block_o <= {link_stream_pkg::HDR_CTRL, 56'h0, link_stream_pkg::TYPE_IDLE};
      end
    end
  end

  // Receive side
  logic           rx_is_data;
  logic           rx_is_sep;
  logic [DW-1:0]  rx_pay;
  logic [DW-1:0]  old_word_r;
  logic           old_v_r;
  logic [DW-1:0]  new_word_r;
  logic           new_v_r;
  logic [31:0]    rx_crc_r;
  logic [31:0]    rx_crc_fin;

  assign rx_pay     = lane_rx_block_i[DW-1:0];
  assign rx_is_data = lane_rx_valid_i && lane_rx_block_i[DW +: 2] == link_stream_pkg::HDR_DATA;
  assign rx_is_sep  = lane_rx_valid_i && lane_rx_block_i[DW +: 2] == link_stream_pkg::HDR_CTRL &&
                      rx_pay[7:0] == link_stream_pkg::TYPE_SEP;
  assign rx_crc_fin = crc_step(rx_crc_r, old_word_r);

  // Words are offered once, in the cycle they leave the deframer
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !channel_up_i) begin
      port.rx_valid <= 1'b0;
      port.rx_last  <= 1'b0;
      port.rx_data  <= '0;
      port.rx_keep  <= link_stream_pkg::KEEP_FULL;
      crc_error_o   <= 1'b0;
      old_v_r       <= 1'b0;
      new_v_r       <= 1'b0;
      old_word_r    <= '0;
      new_word_r    <= '0;
      rx_crc_r      <= link_stream_pkg::CRC_INIT;
    end else begin
      port.rx_valid <= 1'b0;
      port.rx_last  <= 1'b0;
      crc_error_o   <= 1'b0;
      if (!FRAMING) begin
        port.rx_valid <= rx_is_data;
        port.rx_data  <= rx_pay;
        port.rx_keep  <= link_stream_pkg::KEEP_FULL;
      end else if (rx_is_data) begin
        new_word_r <= rx_pay;
        new_v_r    <= 1'b1;
        if (CRC_EN) begin
          old_word_r <= new_word_r;
          old_v_r    <= new_v_r;
          if (old_v_r) begin
            port.rx_valid <= 1'b1;
            port.rx_data  <= old_word_r;
            port.rx_keep  <= link_stream_pkg::KEEP_FULL;
            rx_crc_r      <= rx_crc_fin;
          end
        end else if (new_v_r) begin
          port.rx_valid <= 1'b1;
          port.rx_data  <= new_word_r;
          port.rx_keep  <= link_stream_pkg::KEEP_FULL;
        end
      end else if (rx_is_sep) begin
        new_v_r  <= 1'b0;
        old_v_r  <= 1'b0;
        rx_crc_r <= link_stream_pkg::CRC_INIT;
        if (CRC_EN) begin
          port.rx_valid <= old_v_r;
          port.rx_last  <= old_v_r;
          port.rx_data  <= old_word_r;
          port.rx_keep  <= new_word_r[link_stream_pkg::CRC_KEEP_LSB +: 4];
          crc_error_o   <= old_v_r && new_v_r && (rx_crc_fin != new_word_r[31:0]);
        end else begin
          port.rx_valid <= new_v_r;
          port.rx_last  <= new_v_r;
          port.rx_data  <= new_word_r;
          port.rx_keep  <= rx_pay[link_stream_pkg::SEP_CNT_LSB +: 4];
        end
      end
    end
  end

endmodule // stream_port_device

// ==== core/stream_port_user.sv ====
// User end of the stream port: a fill-then-send tx FIFO and an rx FIFO.
// Assumes the core end shares the clock and keeps its own handshake.
`timescale 1ns/100ps
module stream_port_user #(
  parameter int DEPTH = link_stream_pkg::USER_DEPTH
) (
  input  wire logic                                ref_clk_i,
  input  wire logic                                rst_n_i,
  stream_port_if.user                              port,
  input  wire logic [link_stream_pkg::DATA_W-1:0]  wr_data_i,
  input  wire logic                                wr_en_i,
  output logic                                     wr_ready_o,
  output logic [link_stream_pkg::DATA_W-1:0]       rd_data_o,
  output logic                                     rd_last_o,
  output logic [link_stream_pkg::KEEP_W-1:0]       rd_keep_o,
  output logic                                     rd_valid_o,
  input  wire logic                                rd_ready_i,
  output logic                                     overflow_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int DW = link_stream_pkg::DATA_W;
  localparam int RW = DW + 1 + link_stream_pkg::KEEP_W;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef enum logic [1:0] {
    SRC_FILL = 2'b01,
    SRC_SEND = 2'b10
  } src_state_t;

  logic [DW-1:0] tx_mem [DEPTH];
  logic [RW-1:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r;
  logic [AW-1:0] tx_rp_r;
  logic [AW:0]   tx_cnt_r;
  logic [AW-1:0] rx_wp_r;
  logic [AW-1:0] rx_rp_r;
  logic [AW:0]   rx_cnt_r;
  src_state_t    src_st_r;
  logic          tx_push;
  logic          tx_pop;
  logic          rx_push;
  logic          rx_pop;

  assign tx_push = wr_en_i && wr_ready_o;
  assign tx_pop  = (src_st_r == SRC_SEND) && tx_cnt_r != '0 &&
                   (!port.tx_valid || port.tx_ready);
  assign rx_push = port.rx_valid && rx_cnt_r != FULL_CNT;
  assign rx_pop  = rx_cnt_r != '0 && (!rd_valid_o || rd_ready_i);

  // Source fills the FIFO, then drains it as one frame
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      src_st_r   <= SRC_FILL;
      wr_ready_o <= 1'b0;
    end else begin
      case (src_st_r)
        SRC_FILL: begin
          if (tx_cnt_r + (AW + 1)'(tx_push) == FULL_CNT) begin
            src_st_r <= SRC_SEND;
          end
        end
        SRC_SEND: begin
          if (port.tx_valid && port.tx_ready && port.tx_last) begin
            src_st_r <= SRC_FILL;
          end
        end
        default: src_st_r <= SRC_FILL;
      endcase
      wr_ready_o <= (src_st_r == SRC_FILL) &&
                    (tx_cnt_r + (AW + 1)'(tx_push) < FULL_CNT);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_r] <= wr_data_i;
        tx_wp_r         <= tx_wp_r + AW'(1);
      end
      if (tx_pop) begin
        tx_rp_r <= tx_rp_r + AW'(1);
      end
      tx_cnt_r <= tx_cnt_r + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      port.tx_valid <= 1'b0;
      port.tx_last  <= 1'b0;
      port.tx_data  <= '0;
      port.tx_keep  <= link_stream_pkg::KEEP_FULL;
    end else if (tx_pop) begin
      port.tx_valid <= 1'b1;
      port.tx_data  <= tx_mem[tx_rp_r];
      port.tx_last  <= tx_cnt_r == (AW + 1)'(1);
      port.tx_keep  <= link_stream_pkg::KEEP_FULL;
    end else if (port.tx_ready) begin
      port.tx_valid <= 1'b0;
      port.tx_last  <= 1'b0;
    end
  end

  // Receive FIFO written straight from receive valid
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_wp_r    <= '0;
      rx_rp_r    <= '0;
      rx_cnt_r   <= '0;
      overflow_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
      rd_last_o  <= 1'b0;
      rd_keep_o  <= link_stream_pkg::KEEP_FULL;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_r] <= {port.rx_last, port.rx_keep, port.rx_data};
        rx_wp_r         <= rx_wp_r + AW'(1);
      end
      if (port.rx_valid && !rx_push) begin
        overflow_o <= 1'b1;
      end
      if (rx_pop) begin
        rx_rp_r    <= rx_rp_r + AW'(1);
        rd_valid_o <= 1'b1;
        {rd_last_o, rd_keep_o, rd_data_o} <= rx_mem[rx_rp_r];
      end else if (rd_ready_i) begin
        rd_valid_o <= 1'b0;
      end
      rx_cnt_r <= rx_cnt_r + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
    end
  end
endmodule // stream_port_user

// ==== tb/stream_port_asserts.sv ====
// Concurrent checks on the carrier between the core end and the user end.
// Assumes framing mode, gearbox pause on, one lane looped back to itself.
`timescale 1ns/100ps
module stream_port_asserts (
  input wire logic                               ref_clk_i,
  input wire logic                               rst_n_i,
  input wire logic [link_stream_pkg::DATA_W-1:0] tx_data,
  input wire logic                               tx_valid,
  input wire logic                               tx_last,
  input wire logic [link_stream_pkg::KEEP_W-1:0] tx_keep,
  input wire logic                               tx_ready,
  input wire logic [link_stream_pkg::DATA_W-1:0] rx_data,
  input wire logic                               rx_valid,
  input wire logic                               rx_last,
  input wire logic [link_stream_pkg::KEEP_W-1:0] rx_keep
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic       take;
  logic [5:0] rdy_run_r;
  logic [7:0] backlog_r;
  logic [3:0] last_keep_r;

  assign take = tx_valid && tx_ready;

  // Run of consecutive ready cycles
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !tx_ready) begin
      rdy_run_r <= 6'h00;
    end else begin
      rdy_run_r <= rdy_run_r + 6'h01;
    end
  end

  // Words taken but not yet delivered
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      backlog_r <= 8'h00;
    end else begin
      backlog_r <= backlog_r + {7'h00, take} - {7'h00, rx_valid};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      last_keep_r <= 4'h0;
    end else if (take && tx_last) begin
      last_keep_r <= tx_keep;
    end
  end

  sequence take_last_s;
    take && tx_last;
  endsequence

  sequence rx_last_s;
    rx_valid && rx_last;
  endsequence

  reset_quiet_a: assert property ($rose(rst_n_i) |->
    !tx_ready && !rx_valid && !rx_last && !tx_valid)
    else $error("outputs active at reset release");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last) && $stable(tx_keep))
    else $error("offered word changed before taken");
  gearbox_pause_a: assert property (tx_ready |-> rdy_run_r <= 6'h1E)
    else $error("ready high for 32 cycles");
  separator_slot_a: assert property (take_last_s |=> !tx_ready)
    else $error("no separator slot after last word");
  payload_only_a: assert property (rx_valid |-> backlog_r != 8'h00)
    else $error("word delivered that was never sent");
  frame_end_a: assert property (take_last_s |-> ##[2:12] rx_last_s)
    else $error("frame end not delivered");
  last_has_valid_a: assert property (rx_last |-> rx_valid)
    else $error("frame end without valid");
  keep_match_a: assert property (rx_last_s |-> rx_keep == last_keep_r)
    else $error("receive byte count differs from sent");
  keep_range_a: assert property (rx_last_s |->
    rx_keep >= 4'h1 && rx_keep <= link_stream_pkg::KEEP_FULL)
    else $error("receive byte count out of range");
endmodule // stream_port_asserts

// ==== tb/testbench.sv ====
// Self-checking bench: core end and user end joined, lane looped back.
// Assumes package, interface and both design ends are compiled first.
`timescale 1ns/100ps
module testbench;
  localparam int DEPTH = 4;
  localparam int NROWS = 8;
  localparam int DLY   = 1;
  localparam int CC_P  = 40;

  typedef struct packed {
    logic [link_stream_pkg::DATA_W-1:0] wr_data;
    logic [link_stream_pkg::DATA_W-1:0] exp_data;
    logic                               exp_last;
  } row_t;

  logic                                ref_clk_i  = 1'b0;
  logic                                rst_n_i    = 1'b0;
  logic                                channel_up = 1'b0;
  logic [link_stream_pkg::DATA_W-1:0]  wr_data    = '0;
  logic                                wr_en      = 1'b0;
  logic                                rd_ready   = 1'b1;
  wire logic                           wr_ready_o;
  wire logic [link_stream_pkg::DATA_W-1:0] rd_data_o;
  wire logic                           rd_last_o;
  wire logic [link_stream_pkg::KEEP_W-1:0] rd_keep_o;
  wire logic                           rd_valid_o;
  logic                                overflow_o;
  wire logic [link_stream_pkg::BLOCK_W-1:0] lane_block;
  wire logic                           lane_slot;
  wire logic [link_stream_pkg::BLOCK_W-1:0] strm_block;
  wire logic                           strm_slot;
  wire logic                           strm_cc_req;
  int                                  n_cc;
  row_t                                rows [NROWS];
  int                                  num_errors = 0;
  int                                  n_compared = 0;

  always #4 ref_clk_i = ~ref_clk_i;

  stream_port_if port_link ();
  stream_port_if port_strm ();

  // Second core end in streaming mode, driven straight by the bench
  stream_port_device #(.FRAMING(1'b0), .CC_PERIOD(CC_P)) i_stream_port_device_strm (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .port(port_strm),
    .channel_up_i(channel_up), .lane_tx_block_o(strm_block),
    .lane_tx_slot_o(strm_slot), .clock_comp_request_o(strm_cc_req),
    .lane_rx_block_i(strm_block), .lane_rx_valid_i(strm_slot), .crc_error_o()
  );

  stream_port_device #(.CC_PERIOD(CC_P)) i_stream_port_device (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .port(port_link),
    .channel_up_i(channel_up), .lane_tx_block_o(lane_block),
    .lane_tx_slot_o(lane_slot), .clock_comp_request_o(),
    .lane_rx_block_i(lane_block), .lane_rx_valid_i(lane_slot), .crc_error_o()
  );

  stream_port_user #(.DEPTH(DEPTH)) i_stream_port_user (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .port(port_link),
    .wr_data_i(wr_data), .wr_en_i(wr_en), .wr_ready_o(wr_ready_o),
    .rd_data_o(rd_data_o), .rd_last_o(rd_last_o), .rd_keep_o(rd_keep_o),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready), .overflow_o(overflow_o)
  );

  stream_port_asserts i_stream_port_asserts (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .tx_data(port_link.tx_data), .tx_valid(port_link.tx_valid),
    .tx_last(port_link.tx_last), .tx_keep(port_link.tx_keep),
    .tx_ready(port_link.tx_ready), .rx_data(port_link.rx_data),
    .rx_valid(port_link.rx_valid), .rx_last(port_link.rx_last),
    .rx_keep(port_link.rx_keep)
  );

  task automatic cyc();
    @(posedge ref_clk_i);
    #DLY;
  endtask

  task automatic check(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      num_errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One pulse per word, at least one edge between pulses
  task automatic write_rows(input int first, input int cnt);
    int n;
    for (int i = first; i < first + cnt; i++) begin
      n = 0;
      do begin
        cyc();
        n++;
      end while (wr_ready_o !== 1'b1 && n < 400);
      check(wr_ready_o === 1'b1, "write side never ready");
      wr_data = rows[i].wr_data;
      wr_en   = 1'b1;
      cyc();
      wr_en   = 1'b0;
    end
  endtask

  task automatic read_expect(input int first, input int cnt);
    int n;
    int k;
    n = 0;
    k = first;
    // A standing word is consumed at the next edge, so look before it
    while (k < first + cnt && n < 400) begin
      if (rd_valid_o === 1'b1) begin
        check(rd_data_o === rows[k].exp_data && rd_last_o === rows[k].exp_last &&
              (!rows[k].exp_last || rd_keep_o === link_stream_pkg::KEEP_FULL),
              "received word mismatch");
        k++;
      end
      cyc();
      n++;
    end
    check(k == first + cnt, "received words missing");
  endtask

  // Offer one streaming word, hold it until taken, then watch the pipe
  task automatic stream_word(input logic [link_stream_pkg::DATA_W-1:0] d);
    int n;
    n = 0;
    port_strm.tx_data  = d;
    port_strm.tx_valid = 1'b1;
    while (port_strm.tx_ready !== 1'b1 && n < 50) begin
      cyc();
      n++;
    end
    check(port_strm.tx_ready === 1'b1, "stream never ready");
    cyc();
    port_strm.tx_valid = 1'b0;
    check(port_strm.rx_valid === 1'b0, "stream word early");
    cyc();
    check(port_strm.rx_valid === 1'b1 && port_strm.rx_data === d &&
          port_strm.rx_keep === link_stream_pkg::KEEP_FULL, "stream word lost");
  endtask

  task automatic wait_flag(ref logic flag, input string msg);
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 300) begin
      cyc();
      n++;
    end
    check(flag === 1'b1, msg);
  endtask

  initial begin
    for (int i = 0; i < NROWS; i++) begin
      rows[i].wr_data  = 64'hC0DE00000000A500 + 64'(i);
      rows[i].exp_data = rows[i].wr_data;
      rows[i].exp_last = (i % DEPTH) == (DEPTH - 1);
    end
    port_strm.tx_data  = '0;
    port_strm.tx_valid = 1'b0;
    port_strm.tx_last  = 1'b0;
    port_strm.tx_keep  = link_stream_pkg::KEEP_FULL;
    repeat (2) cyc();
    rst_n_i = 1'b1;
    // Ordinary frames; link held down at first
    fork
      write_rows(0, NROWS);
      read_expect(0, NROWS);
      begin
        repeat (20) cyc();
        check(port_link.tx_ready === 1'b0 && rd_valid_o === 1'b0, "active while down");
        channel_up = 1'b1;
      end
    join
    // Streaming pipe: words come back with the gaps between them
    for (int i = 0; i < NROWS; i++) begin
      stream_word(rows[i].wr_data);
    end
    n_cc = 0;
    for (int i = 0; i < CC_P; i++) begin
      cyc();
      if (strm_cc_req === 1'b1) begin
        n_cc++;
        check(port_strm.tx_ready === 1'b0, "ready during compensation");
      end
    end
    check(n_cc == link_stream_pkg::CC_LEN, "compensation length wrong");
    // No receive backpressure: a stalled reader loses words
    rd_ready = 1'b0;
    write_rows(0, NROWS);
    wait_flag(overflow_o, "stalled reader kept all words");
    rd_ready = 1'b1;
    read_expect(0, DEPTH);
    // Reset in mid-frame
    write_rows(4, DEPTH);
    wait_flag(port_link.tx_valid, "frame never offered");
    rst_n_i = 1'b0;
    cyc();
    check(port_link.tx_ready === 1'b0 && port_link.rx_valid === 1'b0 &&
          port_link.rx_last === 1'b0 && port_link.tx_valid === 1'b0 &&
          rd_valid_o === 1'b0 && overflow_o === 1'b0 && wr_ready_o === 1'b0,
          "outputs active in reset");
    cyc();
    rst_n_i = 1'b1;
    fork
      write_rows(0, DEPTH);
      read_expect(0, DEPTH);
    join
    give_verdict();
  end
endmodule // testbench
